// ==== design/clock_ram_serial_slave_port.sv ====
`timescale 1ns/100ps
`include "rtc_i2c_regs.svh"
module clock_ram_serial_slave_port (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Supply monitor, high while below power_on_reset_threshold
  input wire logic I_POWER_ON_RESET,
  // Serial bus pins
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // Memory side
  output rtc_i2c_pkg::mem_req_t O_MEM_REQ,
  input wire logic [7:0] I_MEM_RDATA,
  // Status
  output logic O_BUSY
);

  ////////////////////////////////////////////////////////////////////////
  logic port_rst;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r;
  logic sda_f_r;
  logic [3:0] scl_cnt_r;
  logic [3:0] sda_cnt_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  rtc_i2c_pkg::port_state_t state_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic first_seen_r;
  logic drive_low_r;
  logic [7:0] waddr_r;
  logic [7:0] tx_r;
  logic mack_r;

  assign port_rst = I_RESET | I_POWER_ON_RESET;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; stage one only feeds stage two
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], I_SCL};
      sda_s_r <= {sda_s_r[1:0], I_SDA};
    end
  end

  // Spike filter
  // A level must hold agreed for the spike window before it counts
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      scl_f_r <= 1'b1;
      scl_cnt_r <= 4'h0;
    end else if (scl_s_r[1] != scl_s_r[2] || scl_s_r[2] == scl_f_r) begin
      scl_cnt_r <= 4'h0;
    end else if (scl_cnt_r == 4'(`SPIKE_CYC)) begin
      scl_f_r <= scl_s_r[2];
      scl_cnt_r <= 4'h0;
    end else begin
      scl_cnt_r <= scl_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      sda_f_r <= 1'b1;
      sda_cnt_r <= 4'h0;
    end else if (sda_s_r[1] != sda_s_r[2] || sda_s_r[2] == sda_f_r) begin
      sda_cnt_r <= 4'h0;
    end else if (sda_cnt_r == 4'(`SPIKE_CYC)) begin
      sda_f_r <= sda_s_r[2];
      sda_cnt_r <= 4'h0;
    end else begin
      sda_cnt_r <= sda_cnt_r + 4'h1;
    end
  end

  // Delayed filtered levels for edge detection
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  assign scl_rise = scl_f_r & ~scl_d_r;
  assign scl_fall = ~scl_f_r & scl_d_r;
  assign start_c = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  // Data change with clock high is control
  assign stop_c = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

  ////////////////////////////////////////////////////////////////////////
  // Bit sequencer; data sampled on clock rise, driven after clock fall
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      state_r <= rtc_i2c_pkg::ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_c) begin
      state_r <= rtc_i2c_pkg::ST_ADDR;
      bit_r <= 4'h0;
    end else if (stop_c) begin
      state_r <= rtc_i2c_pkg::ST_IDLE;
    end else begin
      case (state_r)
        rtc_i2c_pkg::ST_ADDR, rtc_i2c_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f_r};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == `BYTE_BITS) begin
            bit_r <= 4'h0;
            if (state_r == rtc_i2c_pkg::ST_ADDR) begin
              if (shift_r[7:4] == `DEV_GROUP) begin
                rw_r <= shift_r[0];
                state_r <= rtc_i2c_pkg::ST_ACK;
              end else begin
                state_r <= rtc_i2c_pkg::ST_IGNORE;
              end
            end else begin
              state_r <= rtc_i2c_pkg::ST_ACK;
            end
          end
        end
        rtc_i2c_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_r <= rw_r ? rtc_i2c_pkg::ST_TX : rtc_i2c_pkg::ST_RX;
          end
        end
        rtc_i2c_pkg::ST_TX: begin
          if (scl_rise) begin
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == `BYTE_BITS) begin
            bit_r <= 4'h0;
            state_r <= rtc_i2c_pkg::ST_MACK;
          end
        end
        rtc_i2c_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_f_r;
          end else if (scl_fall) begin
            state_r <= mack_r ? rtc_i2c_pkg::ST_TX : rtc_i2c_pkg::ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word address: first written byte loads it, later bytes advance it
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      waddr_r <= `WADDR_RST;
    end else if (state_r == rtc_i2c_pkg::ST_RX && scl_fall &&
                 bit_r == `BYTE_BITS) begin
      if (!first_seen_r) begin
        waddr_r <= shift_r;
      end else begin
        waddr_r <= waddr_r + 8'h01;
      end
    end else if (state_r == rtc_i2c_pkg::ST_TX && scl_fall &&
                 bit_r == `BYTE_BITS) begin
      // Step early so the next read byte is ready by the ack slot end
      waddr_r <= waddr_r + 8'h01;
    end
  end

  // First-byte flag set once the word address is taken, cleared by a start
  always_ff @(posedge I_CLOCK) begin
    if (port_rst || start_c) begin
      first_seen_r <= 1'b0;
    end else if (state_r == rtc_i2c_pkg::ST_RX && scl_fall &&
                 bit_r == `BYTE_BITS) begin
      first_seen_r <= 1'b1;
    end
  end

  // Memory requests, one cycle pulses from flops
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      O_MEM_REQ <= '0;
    end else begin
      O_MEM_REQ.wr <= state_r == rtc_i2c_pkg::ST_RX && scl_fall &&
                      bit_r == `BYTE_BITS && first_seen_r;
      O_MEM_REQ.rd <= scl_fall &&
                      ((state_r == rtc_i2c_pkg::ST_ACK && rw_r) ||
                       (state_r == rtc_i2c_pkg::ST_MACK && mack_r));
      O_MEM_REQ.addr <= waddr_r;
      O_MEM_REQ.wdata <= shift_r;
    end
  end

  // Transmit byte; loaded at start of each byte, shifted after each fall
  always_ff @(posedge I_CLOCK) begin
    if (port_rst) begin
      tx_r <= 8'h00;
    end else if ((state_r == rtc_i2c_pkg::ST_ACK ||
                  state_r == rtc_i2c_pkg::ST_MACK) && scl_fall) begin
      tx_r <= I_MEM_RDATA;
    end else if (state_r == rtc_i2c_pkg::ST_TX && scl_fall) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line drive, changed after a clock fall, released by a start or stop
  always_ff @(posedge I_CLOCK) begin
    if (port_rst || start_c || stop_c) begin
      drive_low_r <= 1'b0;
    end else if (scl_fall) begin
      if (state_r == rtc_i2c_pkg::ST_ADDR || state_r == rtc_i2c_pkg::ST_RX)
      begin
        drive_low_r <= bit_r == `BYTE_BITS &&
                       (state_r == rtc_i2c_pkg::ST_RX ||
                        shift_r[7:4] == `DEV_GROUP);
      end else if (state_r == rtc_i2c_pkg::ST_ACK && rw_r) begin
        drive_low_r <= ~I_MEM_RDATA[7];
      end else if (state_r == rtc_i2c_pkg::ST_TX) begin
        drive_low_r <= bit_r != `BYTE_BITS && ~tx_r[6];
      end else if (state_r == rtc_i2c_pkg::ST_MACK) begin
        drive_low_r <= mack_r && ~I_MEM_RDATA[7];
      end else begin
        drive_low_r <= 1'b0;
      end
    end
  end

  // Open drain: only ever drives low
  assign O_SDA = 1'b0;
  assign O_SDA_OE = drive_low_r;
  assign O_BUSY = state_r != rtc_i2c_pkg::ST_IDLE;

endmodule

// ==== design/rtc_i2c_regs.svh ====
`ifndef RTC_I2C_REGS_SVH
`define RTC_I2C_REGS_SVH
// Fixed upper address group of this device type
`define DEV_GROUP 4'ha
// Bits per byte on the bus
`define BYTE_BITS 4'h8
// Clock period in ns
`define CLK_PERIOD_NS 40
// Tolerable spike width in ns
`define SPIKE_NS 100
// Filter cycles, spike width rounded up to whole cycles, plus one
`define SPIKE_CYC (((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
// Reset value of the word address
`define WADDR_RST 8'h00
`endif

// ==== design/rtc_i2c_pkg.sv ====
package rtc_i2c_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } port_state_t;
  // Memory side request toward the RAM
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage

// ==== testbench/clock_ram_serial_slave_port_chk.sv ====
`timescale 1ns/100ps
module clock_ram_serial_slave_port_chk (
  // Clock and resets
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_POWER_ON_RESET,
  // Bus and memory side
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire rtc_i2c_pkg::mem_req_t O_MEM_REQ,
  input wire logic O_BUSY
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET || I_POWER_ON_RESET);
  logic [7:0] wa_r;
  logic wseen_r;
  // Track last write address; a stop forgets it
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || !O_BUSY)
      wseen_r <= 1'b0;
    else if (O_MEM_REQ.wr)
      wseen_r <= 1'b1;
  end
  always_ff @(posedge I_CLOCK) begin
    if (O_MEM_REQ.wr)
      wa_r <= O_MEM_REQ.addr;
  end
  AST_SDA_LOW: assert property (O_SDA == 1'b0)
    else $error("data pin value not low");
  AST_POR_QUIET: assert property (disable iff (I_RESET)
    I_POWER_ON_RESET |=> !O_BUSY && !O_SDA_OE)
    else $error("port active under supply reset");
  AST_IDLE_FREE: assert property (!O_BUSY && !$past(O_BUSY) |-> !O_SDA_OE)
    else $error("data pulled low on idle bus");
  AST_ADDR_STEP: assert property (O_MEM_REQ.wr && wseen_r |->
    O_MEM_REQ.addr == wa_r + 8'h01)
    else $error("write address did not step");
  AST_REQ_BUSY: assert property (O_MEM_REQ.wr || O_MEM_REQ.rd |-> O_BUSY)
    else $error("memory access outside transfer");
  AST_OE_SCL_LOW: assert property ($changed(O_SDA_OE) |-> !$past(I_SCL, 4))
    else $error("data drive changed with clock high");
  AST_OE_HOLD: assert property ($rose(O_SDA_OE) |=> O_SDA_OE [*8])
    else $error("low drive too short");
  AST_START: assert property ((I_SCL && $fell(I_SDA)) ##1
    (I_SCL && !I_SDA) [*5] |-> ##[1:8] O_BUSY)
    else $error("start not taken");
  AST_STOP: assert property ((I_SCL && $rose(I_SDA)) ##1
    (I_SCL && I_SDA) [*5] |-> ##[1:8] !O_BUSY)
    else $error("stop not taken");
  cover property (O_MEM_REQ.wr);
  cover property (O_MEM_REQ.rd);
  cover property ($rose(O_SDA_OE));
endmodule
bind clock_ram_serial_slave_port clock_ram_serial_slave_port_chk i_chk (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_POWER_ON_RESET(I_POWER_ON_RESET),
  .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
  .O_MEM_REQ(O_MEM_REQ), .O_BUSY(O_BUSY));

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Quarter bit; wide enough for the design's line filter
  localparam int Q = 320;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    #Q sda_o = 1'b1;
    #(2*Q) scl_o = 1'b1;
    #(2*Q) sda_o = 1'b0;
    #(2*Q) scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #(2*Q) sda_o = 1'b1;
    #(2*Q);
  endtask
  // data moves only with clock low
  task automatic xbit(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #(2*Q) r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, ack);
  endtask
  // acks all but the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(last, r);
  endtask
endmodule

// ==== testbench/test_clock_ram_serial_slave_port.sv ====
`timescale 1ns/100ps
module test_clock_ram_serial_slave_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic scl, sda_m, sda_oe, sda_out, busy, a;
  logic [7:0] d;
  logic [7:0] mem [256];
  rtc_i2c_pkg::mem_req_t req;
  int n_errors = 0;
  int check_count = 0;
  // Pull-up: the port can only pull low
  wire sda = sda_m & ~sda_oe;
  wire [7:0] rdata = mem[req.addr];
  always #20 clk = ~clk;
  // Memory stand-in behind the port
  always @(posedge clk) begin
    if (req.wr === 1'b1)
      mem[req.addr] <= req.wdata;
  end
  i2c_master_model i_i2c_master_model (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  clock_ram_serial_slave_port i_clock_ram_serial_slave_port (
    .I_CLOCK(clk), .I_RESET(rst), .I_POWER_ON_RESET(por), .I_SCL(scl),
    .I_SDA(sda), .O_SDA(sda_out), .O_SDA_OE(sda_oe), .O_MEM_REQ(req),
    .I_MEM_RDATA(rdata), .O_BUSY(busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 40 && busy !== v; i++) @(posedge clk);
    check(busy, v);
    if (busy !== v) stop_test();
  endtask
  task automatic t_spike();
    @(posedge clk);
    #5 i_i2c_master_model.sda_o = 1'b0;
    #80 i_i2c_master_model.sda_o = 1'b1;
    repeat (20) @(posedge clk);
    check(busy, 1'b0);
  endtask
  task automatic t_write();
    @(posedge clk);
    #5;
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte(8'ha0, a);
    check(a, 1'b0);
    check(busy, 1'b1);
    i_i2c_master_model.wbyte(8'h10, a);
    check(a, 1'b0);
    for (logic [7:0] k = 0; k < 3; k++) begin
      i_i2c_master_model.wbyte(8'hc3 ^ k, a);
      check(a, 1'b0);
    end
    i_i2c_master_model.stop();
    wait_busy(1'b0);
    for (logic [7:0] k = 0; k < 3; k++) check(mem[8'h10 + k], 8'hc3 ^ k);
  endtask
  task automatic t_read();
    @(posedge clk);
    #5;
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte(8'ha0, a);
    i_i2c_master_model.wbyte(8'h10, a);
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte(8'ha1, a);
    check(a, 1'b0);
    for (logic [7:0] k = 0; k < 3; k++) begin
      i_i2c_master_model.rbyte(k == 2, d);
      check(d, 8'hc3 ^ k);
    end
    #320 check(sda, 1'b1);
    i_i2c_master_model.stop();
    wait_busy(1'b0);
  endtask
  task automatic t_nomatch();
    @(posedge clk);
    #5;
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte(8'h50, a);
    check(a, 1'b1);
    i_i2c_master_model.wbyte(8'ha0, a);
    check(a, 1'b1);
    i_i2c_master_model.stop();
  endtask
  task automatic t_por();
    @(posedge clk);
    #5;
    i_i2c_master_model.start();
    i_i2c_master_model.wbyte(8'ha0, a);
    @(posedge clk) por <= 1'b1;
    repeat (3) @(posedge clk);
    check(busy, 1'b0);
    por <= 1'b0;
    #5;
    i_i2c_master_model.stop();
  endtask
  // Sequence after 20 cycles of reset; a hang ends the run too
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_spike();
    t_nomatch();
    t_por();
    t_write();
    t_read();
    stop_test();
  end
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
endmodule
